// >>> rtl/csft_top.sv
// The address map and the strobed register port were decided locally.
`timescale 1ns/1ps
// Behaviour
// (RULE1) Opcode 1010000111 is skip-if-conversion-done, one word, one cycle.
// (RULE2) Enable bit 0: skip next instruction when conversion flag is 1.
// (RULE3) Enable bit 0: executing it clears the conversion flag.
// (RULE4) Enable bit 1: the instruction is a no-operation.
// (RULE5) Conversion enable bit is bit 2 of control register two.
// (RULE6) Opcode 0000111010 is skip-on-pin-level, one word, one cycle.
// (RULE7) Polarity bit 0: skip next instruction when the pin is low.
// (RULE8) Polarity bit 1: skip next instruction when the pin is high.
// (RULE9) Polarity bit is bit 2 of control register one.
// (RULE10) A skipped instruction does nothing but still uses its cycle.
module csft_top #(
	parameter int CYCLE_DIV = csft_pkg::CYCLE_DIV_DEF
) (
	input wire logic CLOCK,
	input wire logic SRST,
	input csft_pkg::csft_bus_t BUS,
	output logic [csft_pkg::DATA_W-1:0] RDATA,
	input csft_pkg::csft_instr_t INSTR,
	input wire logic CONV_DONE,
	input wire logic EXT_PIN,
	output logic CYCLE_TICK,
	output logic EXEC_OK,
	output logic SKIP_PENDING,
	output logic CONV_FLAG
);
	import csft_pkg::*;

	localparam int CW = (CYCLE_DIV > 1) ? $clog2(CYCLE_DIV) : 1;
	localparam logic [CW-1:0] CNT_LAST = CW'(CYCLE_DIV - 1);

	logic [CW-1:0] cnt;
	logic cycle_tick;
	logic take;
	logic exec_ok;
	logic [3:0] ctrl_one;
	logic [3:0] ctrl_two;
	logic flag;
	logic pin_s;
	logic conv_ie;
	logic pol;
	logic do_conv;
	logic do_pin;
	logic pin_match;
	logic sw_clear;
	csft_state_t state;
	csft_state_t next_state;
	csft_dec_t dec;

	// ----------------------------------------
	// Instruction cycle divider
	// ----------------------------------------
	// One enable pulse per instruction cycle; the core offers a word on it
	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			cnt <= '0;
		end else if (cnt == CNT_LAST) begin
			cnt <= '0;
		end else begin
			cnt <= cnt + 1'b1;
		end
	end

	assign cycle_tick = (cnt == CNT_LAST);
	assign CYCLE_TICK = cycle_tick;

	// ----------------------------------------
	// Pin synchroniser and decoder
	// ----------------------------------------
	csft_sync #(
		.WIDTH(1)
	) u_sync (
		.clock(CLOCK),
		.srst(SRST),
		.async_in(EXT_PIN),
		.sync_out(pin_s)
	);

	csft_decode u_decode (
		.code(INSTR.code),
		.dec(dec)
	);

	// ----------------------------------------
	// Execute qualifiers
	// ----------------------------------------
	assign take = INSTR.valid & cycle_tick;
	assign exec_ok = take & (state == CSFT_RUN); // RULE10
	assign EXEC_OK = exec_ok;
	assign conv_ie = ctrl_two[CONV_IE_BIT]; // RULE5
	assign pol = ctrl_one[POL_BIT]; // RULE9
	// Enable set turns the instruction into a no-operation
	assign do_conv = exec_ok & dec.skip_conv & ~conv_ie; // RULE4
	assign do_pin = exec_ok & dec.skip_pin;
	// Polarity bit picks which level counts as a hit
	assign pin_match = (pin_s == pol); // RULE7 RULE8

	// ----------------------------------------
	// Register writes
	// ----------------------------------------
	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			ctrl_one <= CTRL_ONE_RST;
		end else if (BUS.wr && BUS.addr == ADDR_CTRL_ONE) begin
			ctrl_one <= BUS.wdata;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			ctrl_two <= CTRL_TWO_RST;
		end else if (BUS.wr && BUS.addr == ADDR_CTRL_TWO) begin
			ctrl_two <= BUS.wdata;
		end
	end

	// Writing one to the flag position of status clears the flag
	assign sw_clear = BUS.wr && (BUS.addr == ADDR_STATUS) && BUS.wdata[ST_FLAG_BIT];

	// ----------------------------------------
	// Conversion completion flag
	// ----------------------------------------
	// A completion in the clearing cycle survives: set beats every clear
	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			flag <= FLAG_RST;
		end else if (CONV_DONE) begin
			flag <= 1'b1;
		end else if (do_conv) begin
			flag <= 1'b0; // RULE3
		end else if (sw_clear) begin
			flag <= 1'b0;
		end
	end

	assign CONV_FLAG = flag;

	// ----------------------------------------
	// Skip sequencer
	// ----------------------------------------
	// Test uses the flag value before this cycle's clear
	always_comb begin
		next_state = state;
		if (take) begin
			unique case (state)
				CSFT_SKIP: begin
					next_state = CSFT_RUN; // RULE10
				end
				CSFT_RUN: begin
					if (do_conv && flag) begin
						next_state = CSFT_SKIP; // RULE2
					end else if (do_pin && pin_match) begin
						next_state = CSFT_SKIP; // RULE7 RULE8
					end else begin
						next_state = CSFT_RUN;
					end
				end
			endcase
		end
	end

	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			state <= CSFT_RUN;
		end else begin
			state <= next_state;
		end
	end

	assign SKIP_PENDING = (state == CSFT_SKIP);

	// ----------------------------------------
	// Register reads
	// ----------------------------------------
	// Unmapped address reads zero; data stands one cycle after the strobe
	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			RDATA <= '0;
		end else if (BUS.rd) begin
			unique case (BUS.addr)
				ADDR_CTRL_ONE: begin
					RDATA <= ctrl_one;
				end
				ADDR_CTRL_TWO: begin
					RDATA <= ctrl_two;
				end
				ADDR_STATUS: begin
					RDATA <= {1'b0, pin_s, (state == CSFT_SKIP), flag};
				end
				default: begin
					RDATA <= '0;
				end
			endcase
		end else begin
			RDATA <= '0;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge CLOCK);
	endclocking
	default disable iff (SRST);

	sequence conv_op_s;
		take && state == CSFT_RUN && INSTR.code == OPC_SKIP_CONV;
	endsequence

	sequence pin_op_s;
		take && state == CSFT_RUN && INSTR.code == OPC_SKIP_PIN;
	endsequence

	sequence set_ie_s;
		BUS.wr && BUS.addr == ADDR_CTRL_TWO && BUS.wdata == 4'h4;
	endsequence

	sequence set_pol_s;
		BUS.wr && BUS.addr == ADDR_CTRL_ONE && BUS.wdata == 4'h4;
	endsequence

	conv_skip_a: assert property ( // RULE2
		conv_op_s ##0 (!ctrl_two[2] && flag) |=> state == CSFT_SKIP
	) else $error("conversion skip not taken");

	conv_noskip_a: assert property ( // RULE2
		conv_op_s ##0 (!ctrl_two[2] && !flag) |=> state == CSFT_RUN
	) else $error("conversion skip taken without flag");

	conv_clear_a: assert property ( // RULE3
		conv_op_s ##0 (!ctrl_two[2] && !CONV_DONE) |=> !flag
	) else $error("conversion flag not cleared");

	conv_nop_a: assert property ( // RULE4
		conv_op_s ##0 (ctrl_two[2] && !CONV_DONE && !BUS.wr) |=>
			(flag == $past(flag) && state == CSFT_RUN)
	) else $error("conversion test not a no-operation");

	conv_gate_a: assert property ( // RULE5
		conv_op_s ##0 (ctrl_two[CONV_IE_BIT] && flag && !BUS.wr) |=> state == CSFT_RUN && flag
	) else $error("enable bit two does not gate test");

	conv_one_a: assert property ( // RULE1
		conv_op_s ##0 (!ctrl_two[2] && flag) |-> EXEC_OK ##1 (SKIP_PENDING && !EXEC_OK)
	) else $error("conversion test not single cycle");

	pin_low_a: assert property ( // RULE7
		pin_op_s ##0 (!ctrl_one[2] && !pin_s) |=> state == CSFT_SKIP
	) else $error("low pin skip not taken");

	pin_high_a: assert property ( // RULE8
		pin_op_s ##0 (ctrl_one[2] && pin_s) |=> state == CSFT_SKIP
	) else $error("high pin skip not taken");

	pin_miss_a: assert property ( // RULE6
		pin_op_s ##0 (ctrl_one[2] != pin_s) |=> state == CSFT_RUN
	) else $error("pin skip taken on wrong level");

	pin_pol_a: assert property ( // RULE9
		pin_op_s ##0 (ctrl_one[POL_BIT] == pin_s) |=> state == CSFT_SKIP
	) else $error("polarity bit two not used");

	// A completion or a software clear in the skipped cycle may still move the flag
	skip_drop_a: assert property ( // RULE10
		state == CSFT_SKIP && take && !CONV_DONE && !BUS.wr |->
			!EXEC_OK ##1 (state == CSFT_RUN && $stable(flag))
	) else $error("skipped instruction executed");

	skip_hold_a: assert property ( // RULE10
		state == CSFT_SKIP && !take |=> state == CSFT_SKIP
	) else $error("skip lost before next instruction");

	set_wins_a: assert property (
		CONV_DONE |=> flag
	) else $error("completion lost");

	status_read_a: assert property (
		BUS.rd && BUS.addr == ADDR_STATUS |=> RDATA[0] == $past(flag)
	) else $error("status read wrong");

	flag_hold_a: assert property ( // RULE1
		!(take && state == CSFT_RUN && INSTR.code == OPC_SKIP_CONV) && !CONV_DONE && !BUS.wr
			|=> $stable(flag)
	) else $error("flag moved without its instruction");

	pin_flag_a: assert property ( // RULE6
		pin_op_s ##0 (!CONV_DONE && !BUS.wr) |=> $stable(flag)
	) else $error("pin test touched the flag");

	soft_clear_a: assert property (
		sw_clear && !CONV_DONE |=> !flag
	) else $error("software clear lost");

	skip_lead_a: assert property ( // RULE10
		state == CSFT_RUN && !take |=> state == CSFT_RUN
	) else $error("skip raised without an instruction");

	read_idle_a: assert property (
		!BUS.rd |=> RDATA == '0
	) else $error("read data stood too long");

	tick_gap_a: assert property (
		cycle_tick && CYCLE_DIV > 1 |=> !cycle_tick
	) else $error("instruction cycle tick too long");

	ie_write_a: assert property ( // RULE5
		set_ie_s |=> conv_ie
	) else $error("enable bit two not written");

	pol_write_a: assert property ( // RULE9
		set_pol_s |=> pol
	) else $error("polarity bit two not written");

endmodule

// >>> rtl/csft_pkg.sv
package csft_pkg;

	// ----------------------------------------
	// Instruction words
	// ----------------------------------------
	localparam int INSTR_W = 10;
	localparam logic [9:0] OPC_SKIP_CONV = 10'h287;
	localparam logic [9:0] OPC_SKIP_PIN = 10'h03a;

	// ----------------------------------------
	// Register port
	// ----------------------------------------
	localparam int DATA_W = 4;
	localparam int ADDR_W = 2;
	localparam logic [1:0] ADDR_CTRL_ONE = 2'h0;
	localparam logic [1:0] ADDR_CTRL_TWO = 2'h1;
	localparam logic [1:0] ADDR_STATUS = 2'h2;

	// ----------------------------------------
	// Field positions and reset values
	// ----------------------------------------
	localparam int POL_BIT = 2;
	localparam int CONV_IE_BIT = 2;
	localparam int ST_FLAG_BIT = 0;
	localparam int ST_SKIP_BIT = 1;
	localparam int ST_PIN_BIT = 2;
	localparam logic [3:0] CTRL_ONE_RST = 4'h0;
	localparam logic [3:0] CTRL_TWO_RST = 4'h0;
	localparam logic FLAG_RST = 1'b0;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CYCLE_DIV_DEF = 4;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic {
		CSFT_RUN = 1'b0,
		CSFT_SKIP = 1'b1
	} csft_state_t;

	typedef struct packed {
		logic valid;
		logic [9:0] code;
	} csft_instr_t;

	typedef struct packed {
		logic skip_conv;
		logic skip_pin;
	} csft_dec_t;

	typedef struct packed {
		logic [1:0] addr;
		logic [3:0] wdata;
		logic wr;
		logic rd;
	} csft_bus_t;

endpackage

// >>> rtl/csft_sync.sv
`timescale 1ns/1ps
module csft_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clock,
	input wire logic srst,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	import csft_pkg::*;

	// ----------------------------------------
	// Two-stage synchroniser
	// ----------------------------------------
	// First stage feeds only the second; nothing else may look at it
	logic [WIDTH-1:0] meta;

	always_ff @(posedge clock) begin
		if (srst) begin
			meta <= '0;
			sync_out <= '0;
		end else begin
			meta <= async_in;
			sync_out <= meta;
		end
	end

endmodule

// >>> rtl/csft_decode.sv
`timescale 1ns/1ps
module csft_decode (
	input wire logic [csft_pkg::INSTR_W-1:0] code,
	output csft_pkg::csft_dec_t dec
);
	import csft_pkg::*;

	// ----------------------------------------
	// Opcode match
	// ----------------------------------------
	// Full ten-bit compare; no partial decode aliases other opcodes
	always_comb begin
		dec.skip_conv = (code == OPC_SKIP_CONV); // RULE1
		dec.skip_pin = (code == OPC_SKIP_PIN); // RULE6
	end

endmodule

// >>> testbench/test_conditional_skip_flag_test.sv
`timescale 1ns/1ps
module test_conditional_skip_flag_test;
	import csft_pkg::*;

	// ----------------------------------------
	// Stimulus and observed signals
	// ----------------------------------------
	logic CLOCK = 1'b0;
	logic SRST = 1'b1;
	csft_bus_t BUS = '0;
	csft_instr_t INSTR = '0;
	logic CONV_DONE = 1'b0;
	logic EXT_PIN = 1'b0;
	logic [DATA_W-1:0] RDATA;
	logic CYCLE_TICK;
	logic EXEC_OK;
	logic SKIP_PENDING;
	logic CONV_FLAG;
	int mismatches = 0;
	int n_checks = 0;
	logic s;
	logic [3:0] cfg [4] = '{4'h0, 4'h4, 4'hb, 4'hf};
	localparam int TB_DIV = 4;

	always #2 CLOCK = ~CLOCK;

	csft_top #(.CYCLE_DIV(TB_DIV)) dut_u (
		.CLOCK(CLOCK),
		.SRST(SRST),
		.BUS(BUS),
		.RDATA(RDATA),
		.INSTR(INSTR),
		.CONV_DONE(CONV_DONE),
		.EXT_PIN(EXT_PIN),
		.CYCLE_TICK(CYCLE_TICK),
		.EXEC_OK(EXEC_OK),
		.SKIP_PENDING(SKIP_PENDING),
		.CONV_FLAG(CONV_FLAG)
	);

	// ----------------------------------------
	// Compare and access tasks
	// ----------------------------------------
	task automatic check_bit(input string what, input logic exp, input logic got);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %s expected %b seen %b", what, exp, got);
		end
	endtask

	task automatic check_nib(input string what, input logic [3:0] exp, input logic [3:0] got);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input logic [1:0] a, input logic [3:0] d);
		@(posedge CLOCK);
		BUS <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge CLOCK);
		BUS <= '0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [1:0] a, input logic [3:0] exp);
		@(posedge CLOCK);
		BUS <= '{addr: a, wdata: 4'h0, wr: 1'b0, rd: 1'b1};
		@(posedge CLOCK);
		BUS <= '0;
		#1 check_nib("read data", exp, RDATA);
	endtask

	task automatic done_pulse;
		@(posedge CLOCK);
		CONV_DONE <= 1'b1;
		@(posedge CLOCK);
		CONV_DONE <= 1'b0;
		#1 check_bit("conversion flag set", 1'b1, CONV_FLAG);
	endtask

	// Word offered until a tick takes it; results looked at one cycle on
	task automatic issue(input logic [9:0] c, input logic e_exec, input logic e_skip,
		input logic e_flag);
		bit got_tick;
		got_tick = 1'b0;
		while (!got_tick) begin
			@(posedge CLOCK);
			INSTR <= '{valid: 1'b1, code: c};
			#1 got_tick = (CYCLE_TICK === 1'b1);
		end
		check_bit("execute enable", e_exec, EXEC_OK);
		@(posedge CLOCK);
		INSTR <= '0;
		#1 check_bit("skip pending", e_skip, SKIP_PENDING);
		check_bit("conversion flag", e_flag, CONV_FLAG);
	endtask

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// ----------------------------------------
	// Watchdog
	// ----------------------------------------
	// Whole sequence is well under a thousand cycles
	initial begin
		repeat (5000) @(posedge CLOCK);
		mismatches++;
		report_and_stop;
	end

	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial begin
		repeat (20) @(posedge CLOCK);
		SRST <= 1'b0;
		// Divider restarts from zero; one tick in every TB_DIV cycles
		for (int k = 0; k < 2 * TB_DIV; k++) begin
			@(posedge CLOCK);
			#1 check_bit("cycle tick", ((k + 1) % TB_DIV) == TB_DIV - 1, CYCLE_TICK);
		end
		rd(ADDR_CTRL_ONE, CTRL_ONE_RST);
		rd(ADDR_CTRL_TWO, CTRL_TWO_RST);
		rd(ADDR_STATUS, 4'h0);
		wr(2'h3, 4'hf);
		rd(2'h3, 4'h0);
		wr(ADDR_CTRL_ONE, 4'ha);
		rd(ADDR_CTRL_ONE, 4'ha);
		@(posedge CLOCK);
		#1 check_nib("read data idle", 4'h0, RDATA);
		wr(ADDR_CTRL_TWO, 4'h5);
		rd(ADDR_CTRL_TWO, 4'h5);
		wr(ADDR_CTRL_ONE, 4'h0);
		wr(ADDR_CTRL_TWO, 4'h0);
		// Conversion test with enable bit clear
		issue(OPC_SKIP_CONV, 1'b1, 1'b0, 1'b0);
		done_pulse;
		issue(OPC_SKIP_CONV, 1'b1, 1'b1, 1'b0);
		done_pulse;
		issue(OPC_SKIP_CONV, 1'b0, 1'b0, 1'b1);
		issue(OPC_SKIP_CONV, 1'b1, 1'b1, 1'b0);
		issue(10'h000, 1'b0, 1'b0, 1'b0);
		// Enable bit set turns it into a no-operation
		wr(ADDR_CTRL_TWO, 4'h4);
		done_pulse;
		issue(OPC_SKIP_CONV, 1'b1, 1'b0, 1'b1);
		wr(ADDR_CTRL_TWO, 4'hb);
		issue(OPC_SKIP_CONV, 1'b1, 1'b1, 1'b0);
		issue(10'h000, 1'b0, 1'b0, 1'b0);
		// Near-miss words must not touch the flag
		wr(ADDR_CTRL_TWO, 4'h0);
		done_pulse;
		issue(10'h286, 1'b1, 1'b0, 1'b1);
		issue(10'h387, 1'b1, 1'b0, 1'b1);
		wr(ADDR_STATUS, 4'h1);
		#1 check_bit("flag software clear", 1'b0, CONV_FLAG);
		// Pin test over polarity, pin level and other control bits
		for (int i = 0; i < 8; i++) begin
			wr(ADDR_CTRL_ONE, cfg[i/2]);
			@(posedge CLOCK);
			EXT_PIN <= i[0];
			repeat (3) @(posedge CLOCK);
			s = (i[0] == cfg[i/2][POL_BIT]);
			issue(OPC_SKIP_PIN, 1'b1, s, 1'b0);
			rd(ADDR_STATUS, {1'b0, i[0], s, 1'b0});
			if (s)
				issue(10'h000, 1'b0, 1'b0, 1'b0);
		end
		// Mid-run reset drops a pending skip, the flag and control register one
		done_pulse;
		issue(OPC_SKIP_CONV, 1'b1, 1'b1, 1'b0);
		done_pulse;
		@(posedge CLOCK);
		SRST <= 1'b1;
		repeat (2) @(posedge CLOCK);
		SRST <= 1'b0;
		#1 check_bit("skip after reset", 1'b0, SKIP_PENDING);
		check_bit("flag after reset", FLAG_RST, CONV_FLAG);
		rd(ADDR_CTRL_ONE, CTRL_ONE_RST);
		issue(10'h03b, 1'b1, 1'b0, 1'b0);
		issue(10'h23a, 1'b1, 1'b0, 1'b0);
		report_and_stop;
	end
endmodule
